//--- tpwg_pkg.sv
// Shared constants, register map and types of the pulse/waveform generator
`default_nettype none
package tpwg_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 200_000_000; // System clock rate
  localparam int unsigned CLK_PERIOD_PS = 5000; // One clock period
  localparam int unsigned SAMPLE_PERIOD_PS = 2500; // DAC update interval
  localparam int unsigned SAMPLES_PER_CLK = CLK_PERIOD_PS / SAMPLE_PERIOD_PS;
  localparam int unsigned CLK_NS = CLK_PERIOD_PS / 1000; // Width step in ns
  localparam int unsigned TRIG_POS_NS = 86; // Typical positive response
  localparam int unsigned TRIG_NEG_NS = 175; // Typical negative response
  localparam int unsigned TRIG_POS_CYC = TRIG_POS_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned TRIG_NEG_CYC = TRIG_NEG_NS * 1000 / CLK_PERIOD_PS;
  // Waveform storage geometry
  localparam int unsigned SLOTS = 32; // Waveform slots
  localparam int unsigned SLOT_SAMPLES = 128; // Samples per slot
  localparam int unsigned BEAT_W = 6; // Sample pairs per slot index width
  localparam logic signed [15:0] SAMPLE_MIN = 16'hec9c; // -4964
  localparam logic signed [15:0] SAMPLE_MAX = 16'h53c2; // 21442
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00; // Output control word
  localparam logic [7:0] REG_WIDTH = 8'h04; // Pulse width in ns
  localparam logic [7:0] REG_RATE = 8'h08; // Repetition rate in Hz
  localparam logic [7:0] REG_SHOTS = 8'h0c; // Pulses per edge
  localparam logic [7:0] REG_STATUS = 8'h10; // Live state
  localparam logic [7:0] REG_SAMPLE = 8'h14; // Sample write command
  localparam logic [7:0] REG_SLOT_CFG = 8'h18; // Slot length/delay write
  localparam logic [7:0] REG_FORM_SEL = 8'h1c; // Active slot
  localparam logic [7:0] REG_WIDTH_MAX = 8'h20; // Largest usable width
  localparam logic [7:0] REG_PERIOD = 8'h24; // Period in clock cycles
  localparam logic [3:0] ADC_BLOCK = 4'h3; // Offsets 0x30..0x3c
  localparam logic [3:0] AUX_BLOCK = 4'h4; // Offsets 0x40..0x4c
  // Output control word fields
  localparam int unsigned CTRL_EN_BIT = 0; // Output enable
  localparam int unsigned CTRL_MODE_LSB = 1; // Two-bit trigger mode
  localparam int unsigned CTRL_POL_BIT = 3; // 1 = falling edge / low level
  localparam int unsigned CTRL_AUTO_BIT = 7; // Enable after self test
  // Command field positions
  localparam int unsigned SMP_POS_LSB = 16; // Sample position, 7 bits
  localparam int unsigned SMP_SLOT_LSB = 24; // Sample slot, 5 bits
  localparam int unsigned CFG_LEN_LSB = 8; // Slot length, 7 bits
  localparam int unsigned CFG_DLY_LSB = 16; // Slot start delay, 3 bits
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] WIDTH_RST = 32'h0000_0064; // 100 ns
  localparam logic [31:0] RATE_RST = 32'h0000_03e8; // 1000 Hz
  localparam logic [15:0] SHOTS_RST = 16'h0001;
  localparam logic [31:0] PERIOD_MIN = 32'h0000_0002; // Shortest period
  // Trigger modes
  typedef enum logic [1:0] {
    TPWG_EDGE = 2'b00,
    TPWG_LEVEL = 2'b01,
    TPWG_INTERNAL = 2'b10,
    TPWG_ANALOG = 2'b11
  } tpwg_mode_e;
  // Generator states
  typedef enum logic [0:0] {
    TPWG_IDLE = 1'b0,
    TPWG_RUN = 1'b1
  } tpwg_state_e;
endpackage : tpwg_pkg
`default_nettype wire

//--- tpwg_trig.sv
// Trigger conditioner: selected-polarity edge pulse and level flag
`default_nettype none
module tpwg_trig (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_i,
  input wire logic pol_i,
  output logic edge_o,
  output logic level_o
);
  logic prev_r; // Trigger level one cycle ago
  logic edge_r; // Edge of the chosen polarity seen
  logic level_r; // Trigger sits at the chosen level
  wire logic rise = trig_i & ~prev_r; // Rising transition
  wire logic fall = ~trig_i & prev_r; // Falling transition

  // Register edge and level so the generator sees clean flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
      edge_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      prev_r <= trig_i;
      edge_r <= pol_i ? fall : rise; // [R13] [R14]
      level_r <= pol_i ? ~trig_i : trig_i; // [R13]
    end
  end

  assign edge_o = edge_r;
  assign level_o = level_r;
endmodule : tpwg_trig
`default_nettype wire

//--- tpwg_div.sv
// Serial restoring divider turning a rate in Hz into a period in cycles
`default_nettype none
module tpwg_div #(
  parameter int unsigned W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic [W-1:0] quot_o,
  output logic busy_o
);
  logic [W-1:0] rem_r; // Partial remainder
  logic [W-1:0] q_r; // Quotient under construction
  logic [W-1:0] d_r; // Latched divisor
  logic [7:0] step_r; // Steps still to go
  logic busy_r; // Division in progress
  logic [W-1:0] quot_r; // Last finished quotient
  wire logic [W:0] shifted = {rem_r, q_r[W-1]}; // Remainder with next bit
  wire logic [W:0] diff = shifted - {1'b0, d_r}; // Trial subtraction
  wire logic fits = ~diff[W]; // Divisor fits into remainder
  wire logic [W-1:0] q_next = {q_r[W-2:0], fits};

  // One quotient bit per clock; a zero divisor saturates the result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem_r <= '0;
      q_r <= '0;
      d_r <= '0;
      step_r <= 8'h00;
      busy_r <= 1'b0;
      quot_r <= '1;
    end else if (start_i && !busy_r) begin
      if (divisor_i == '0) begin
        quot_r <= '1; // Zero rate: longest period
      end else begin
        rem_r <= '0;
        q_r <= dividend_i;
        d_r <= divisor_i;
        step_r <= 8'(W);
        busy_r <= 1'b1;
      end
    end else if (busy_r) begin
      rem_r <= fits ? diff[W-1:0] : shifted[W-1:0];
      q_r <= q_next;
      step_r <= step_r - 8'h01;
      if (step_r == 8'h01) begin
        busy_r <= 1'b0;
        quot_r <= q_next;
      end
    end
  end

  assign quot_o = quot_r;
  assign busy_o = busy_r;
endmodule : tpwg_div
`default_nettype wire

//--- tpwg_top.sv
// Triggered pulse and stored-waveform generator with Wishbone registers
//
// Overview of operation
// [R1] Trigger mode value picks digital or analog
// [R2] Analog width in 5 ns steps, 320 ns
// [R3] Two 16-bit samples per clock to DAC
// [R4] Thirty-two slots, one selected for playback
// [R5] Slot length value gives (value+1) samples
// [R6] Slot start delay 0..7 before playback
// [R7] Sample writes carry slot, position, bounded value
// [R8] Trigger modes steer digital pulses, enable required
// [R9] Each chosen edge starts a shot burst
// [R10] Bursts finish; extra edges ignored meanwhile
// [R11] Level mode pulses while trigger holds level
// [R12] Internal mode ignores trigger, runs forever
// [R13] Polarity applies only to edge and level
// [R14] Trigger to output within typical delays
// [R15] Auto enable after self test when set
// [R16] Width limited by period and vice versa; the period here follows the rate only and is never limited by width
// [R17] Width held in ns, rate in Hz
// [R18] Four 12-bit ADC results readable
// [R19] Four 16-bit auxiliary DAC values writable
// [R20] Disable stops output at once
// [R21] Samples signed 16-bit, played from position 0
`default_nettype none
module tpwg_top
  import tpwg_pkg::*;
#(
  parameter int unsigned ADC_W = 12,
  parameter int unsigned AUX_W = 16,
  parameter int unsigned CHANNELS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_i,
  input wire logic self_test_done_i,
  input wire logic [CHANNELS*ADC_W-1:0] adc_i,
  output logic [CHANNELS*AUX_W-1:0] aux_dac_o,
  output logic pulse_o,
  output logic [31:0] dac_data_o,
  output logic [1:0] dac_lane_o,
  output logic dac_valid_o,
  output logic out_en_o
);
  // Register state
  logic ack_r; // Bus acknowledge
  logic [31:0] rdata_r; // Registered read data
  logic [7:0] ctrl_r; // Output control word
  logic [31:0] width_r; // Digital pulse width, ns
  logic [31:0] rate_r; // Repetition rate, Hz
  logic [15:0] shots_r; // Pulses per edge burst
  logic [4:0] form_sel_r; // Active waveform slot
  logic [31:0] period_r; // Period in clock cycles
  logic boot_r; // Starts the first period computation
  // Waveform storage: even and odd sample positions in separate banks
  logic [15:0] mem_even [SLOTS*SLOT_SAMPLES/2];
  logic [15:0] mem_odd [SLOTS*SLOT_SAMPLES/2];
  logic [6:0] len_mem [SLOTS]; // Length value per slot
  logic [2:0] dly_mem [SLOTS]; // Start delay per slot
  // Generator state
  tpwg_state_e state_r;
  logic [31:0] cnt_r; // Cycle within the current period
  logic [15:0] shots_left_r; // Pulses left in this burst
  logic pulse_r; // Rectangular output
  logic [31:0] dac_data_r; // Sample pair for the fast DAC
  logic [1:0] dac_lane_r; // Valid lanes of the pair
  logic dac_valid_r; // Pair is being played

  // Bus decode
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic bus_wr = bus_req & wb_we_i;
  wire logic full_word = wb_sel_i == 4'hf;
  wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic hit_ctrl = wb_adr_i == REG_CTRL;
  wire logic hit_width = wb_adr_i == REG_WIDTH;
  wire logic hit_rate = wb_adr_i == REG_RATE;
  wire logic hit_shots = wb_adr_i == REG_SHOTS;
  wire logic hit_status = wb_adr_i == REG_STATUS;
  wire logic hit_sample = wb_adr_i == REG_SAMPLE;
  wire logic hit_cfg = wb_adr_i == REG_SLOT_CFG;
  wire logic hit_form = wb_adr_i == REG_FORM_SEL;
  wire logic hit_wmax = wb_adr_i == REG_WIDTH_MAX;
  wire logic hit_period = wb_adr_i == REG_PERIOD;
  wire logic hit_adc = wb_adr_i[7:4] == ADC_BLOCK && wb_adr_i[1:0] == 2'b00;
  wire logic hit_aux = wb_adr_i[7:4] == AUX_BLOCK && wb_adr_i[1:0] == 2'b00;
  wire logic [1:0] ch_sel = wb_adr_i[3:2];
  wire logic [31:0] wr_width = (width_r & ~wmask) | (wb_dat_i & wmask);
  wire logic [31:0] wr_rate = (rate_r & ~wmask) | (wb_dat_i & wmask);
  wire logic [31:0] wr_shots = ({16'h0000, shots_r} & ~wmask)
                               | (wb_dat_i & wmask);
  wire logic [31:0] wr_ctrl = ({24'h000000, ctrl_r} & ~wmask)
                              | (wb_dat_i & wmask);

  // Mode and limits
  wire tpwg_mode_e mode = tpwg_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  wire logic en = ctrl_r[CTRL_EN_BIT];
  wire logic analog = mode == TPWG_ANALOG; // [R1]
  wire logic [31:0] width_max = 32'((period_r - 32'h1) * 32'(CLK_NS));
  wire logic [31:0] width_eff = (width_r < width_max) ? width_r
                                                      : width_max; // [R16]
  wire logic [31:0] cnt_ns = 32'(cnt_r * 32'(CLK_NS)); // [R17]
  // Compare with >= so a period shortened mid-run still wraps the counter
  wire logic period_end = cnt_r >= period_r - 32'h1;

  // Trigger conditioning and period computation
  logic edge_hit;
  logic level_hit;
  logic [31:0] div_q;
  logic div_busy;
  tpwg_trig u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_i(trig_i),
    .pol_i(ctrl_r[CTRL_POL_BIT]),
    .edge_o(edge_hit),
    .level_o(level_hit)
  );
  tpwg_div #(.W(32)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i((bus_wr & hit_rate) | boot_r),
    .dividend_i(32'(CLK_HZ)),
    .divisor_i(boot_r ? rate_r : wr_rate), // [R17]
    .quot_o(div_q),
    .busy_o(div_busy)
  );
  wire logic [31:0] period_nxt = (div_q < PERIOD_MIN) ? PERIOD_MIN : div_q;

  // Read selection
  wire logic [31:0] adc_word = 32'(adc_i[ch_sel*ADC_W +: ADC_W]); // [R18]
  wire logic [31:0] aux_word = 32'(aux_dac_o[ch_sel*AUX_W +: AUX_W]);
  wire logic [31:0] status_word = {shots_left_r, 12'h000, div_busy,
                                   dac_valid_r, pulse_r, state_r};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_r} :
    hit_width ? width_r :
    hit_rate ? rate_r :
    hit_shots ? {16'h0000, shots_r} :
    hit_status ? status_word :
    hit_form ? {27'h0000000, form_sel_r} :
    hit_wmax ? width_max :
    hit_period ? period_r :
    hit_adc ? adc_word :
    hit_aux ? aux_word : 32'h0000_0000;

  // Wishbone handshake: one-cycle answer, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      rdata_r <= bus_req ? rd_mux : rdata_r;
    end
  end

  // Control word; the self-test enable wins over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (bus_wr && hit_ctrl) begin
        ctrl_r <= wr_ctrl[7:0];
      end
      if (self_test_done_i && ctrl_r[CTRL_AUTO_BIT]) begin
        ctrl_r[CTRL_EN_BIT] <= 1'b1; // [R15]
      end
    end
  end

  // Pulse parameters and period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      width_r <= WIDTH_RST;
      rate_r <= RATE_RST;
      shots_r <= SHOTS_RST;
      form_sel_r <= 5'h00;
      period_r <= PERIOD_MIN;
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      if (bus_wr && hit_width) begin
        width_r <= (wr_width < width_max) ? wr_width : width_max; // [R16]
      end
      if (bus_wr && hit_rate) begin
        rate_r <= wr_rate; // [R17]
      end
      if (bus_wr && hit_shots) begin
        shots_r <= wr_shots[15:0];
      end
      if (bus_wr && hit_form && wb_sel_i[0]) begin
        form_sel_r <= wb_dat_i[4:0]; // [R4]
      end
      if (!div_busy) begin
        period_r <= period_nxt;
      end
    end
  end

  // Sample command fields
  wire logic [6:0] smp_pos = wb_dat_i[SMP_POS_LSB +: 7];
  wire logic [4:0] smp_slot = wb_dat_i[SMP_SLOT_LSB +: 5];
  wire logic signed [15:0] smp_raw = wb_dat_i[15:0];
  wire logic signed [15:0] smp_val = (smp_raw < SAMPLE_MIN) ? SAMPLE_MIN :
                                     (smp_raw > SAMPLE_MAX) ? SAMPLE_MAX :
                                     smp_raw; // [R7]
  wire logic [10:0] smp_idx = {smp_slot, smp_pos[6:1]};
  wire logic [4:0] cfg_slot = wb_dat_i[4:0];

  // Waveform and slot storage writes; only whole-word commands count
  always_ff @(posedge clk_i) begin
    if (bus_wr && hit_sample && full_word) begin
      if (smp_pos[0]) begin
        mem_odd[smp_idx] <= smp_val; // [R21]
      end else begin
        mem_even[smp_idx] <= smp_val; // [R21]
      end
    end
    if (bus_wr && hit_cfg && full_word) begin
      len_mem[cfg_slot] <= wb_dat_i[CFG_LEN_LSB +: 7]; // [R5]
      dly_mem[cfg_slot] <= wb_dat_i[CFG_DLY_LSB +: 3]; // [R6]
    end
  end

  // Auxiliary DAC channels, one register per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_aux
    logic [AUX_W-1:0] aux_r; // Channel value
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        aux_r <= '0;
      end else if (bus_wr && hit_aux && ch_sel == 2'(ch)) begin
        aux_r <= AUX_W'(wr_aux(aux_r)); // [R19]
      end
    end
    function automatic logic [31:0] wr_aux(input logic [AUX_W-1:0] old);
      wr_aux = (32'(old) & ~wmask) | (wb_dat_i & wmask);
    endfunction : wr_aux
    assign aux_dac_o[ch*AUX_W +: AUX_W] = aux_r;
  end

  // Start condition of a run for each mode
  wire logic go_edge = mode == TPWG_EDGE && edge_hit
                       && shots_r != 16'h0000; // [R9]
  wire logic go_level = mode == TPWG_LEVEL && level_hit; // [R11]
  wire logic go_free = mode == TPWG_INTERNAL || analog; // [R12]
  wire logic go = en && (go_edge || go_level || go_free); // [R8]

  // Generator: period counter with burst, level and free-run endings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= TPWG_IDLE;
      cnt_r <= 32'h0000_0000;
      shots_left_r <= 16'h0000;
    end else begin
      case (state_r)
        TPWG_IDLE: begin
          cnt_r <= 32'h0000_0000;
          if (go) begin
            state_r <= TPWG_RUN;
            shots_left_r <= shots_r; // [R9]
          end
        end
        TPWG_RUN: begin
          if (!en) begin
            state_r <= TPWG_IDLE; // [R20]
          end else if (period_end) begin
            cnt_r <= 32'h0000_0000;
            if (mode == TPWG_EDGE) begin
              // Edges are not looked at here, so a burst completes unless the output is disabled
              shots_left_r <= shots_left_r - 16'h0001; // [R10]
              if (shots_left_r <= 16'h0001) begin
                state_r <= TPWG_IDLE;
              end
            end else if (mode == TPWG_LEVEL && !level_hit) begin
              state_r <= TPWG_IDLE; // [R11]
            end
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        default: begin
          state_r <= TPWG_IDLE;
        end
      endcase
    end
  end

  // Analog playback addressing from the period counter
  wire logic [6:0] cur_len = len_mem[form_sel_r]; // [R4]
  wire logic [31:0] cur_dly = 32'(dly_mem[form_sel_r]); // [R6]
  wire logic [31:0] beats = 32'((8'(cur_len) + 8'h02) >> 1); // [R3]
  wire logic [31:0] beat = cnt_r - cur_dly;
  wire logic running = state_r == TPWG_RUN && en;
  wire logic play = running && analog && cnt_r >= cur_dly
                    && beat < beats; // [R2]
  wire logic [10:0] rd_idx = {form_sel_r, beat[BEAT_W-1:0]}; // [R21]
  wire logic last_half = beat == beats - 32'h1 && !cur_len[0]; // [R5]

  // Output stage: rectangular pulse or sample pairs, never both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
      dac_data_r <= 32'h0000_0000;
      dac_lane_r <= 2'b00;
      dac_valid_r <= 1'b0;
    end else begin
      pulse_r <= running && !analog && cnt_ns < width_eff; // [R1]
      dac_valid_r <= play; // [R3]
      dac_lane_r <= play ? (last_half ? 2'b01 : 2'b11) : 2'b00; // [R5]
      dac_data_r <= play ? {mem_odd[rd_idx], mem_even[rd_idx]}
                         : 32'h0000_0000; // [R3]
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign pulse_o = pulse_r;
  assign dac_data_o = dac_data_r;
  assign dac_lane_o = dac_lane_r;
  assign dac_valid_o = dac_valid_r;
  assign out_en_o = en;

  // Checks on the generator
  localparam int POS_CYC = TRIG_POS_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_digital_only_rect: assert property ( // [R1]
    pulse_r |-> !dac_valid_r)
    else $error("pulse and DAC playback active together");
  chk_disable_stops: assert property ( // [R20]
    !en |=> !pulse_r && !dac_valid_r && state_r == TPWG_IDLE)
    else $error("output active after disable");
  chk_edge_starts: assert property ( // [R9]
    state_r == TPWG_IDLE && go_edge && en
    |=> state_r == TPWG_RUN && shots_left_r == $past(shots_r))
    else $error("edge did not start a burst");
  chk_burst_completes: assert property ( // [R10]
    running && mode == TPWG_EDGE && shots_left_r > 16'h0001
    && period_end |=> state_r == TPWG_RUN)
    else $error("burst cut short");
  chk_level_ends: assert property ( // [R11]
    running && mode == TPWG_LEVEL && period_end && !level_hit
    |=> state_r == TPWG_IDLE)
    else $error("level run kept going");
  chk_internal_free: assert property ( // [R12]
    running && mode == TPWG_INTERNAL |=> state_r == TPWG_RUN)
    else $error("internal run stopped");
  chk_trig_latency: assert property ( // [R14]
    $rose(trig_i) && !ctrl_r[CTRL_POL_BIT] && state_r == TPWG_IDLE
    && en && mode == TPWG_EDGE && shots_r != 16'h0000
    && width_eff != 32'h0 ##1 en [*3]
    |-> ##[0:POS_CYC] pulse_r)
    else $error("trigger response too slow");
  chk_period_gap: assert property ( // [R16]
    running && period_end |=> !pulse_r)
    else $error("pulse fills whole period");
  chk_auto_enable: assert property ( // [R15]
    self_test_done_i && ctrl_r[CTRL_AUTO_BIT] |=> en)
    else $error("auto enable missing");
  chk_start_delay: assert property ( // [R6]
    running && analog && cnt_r < cur_dly |=> !dac_valid_r)
    else $error("playback before start delay");
  chk_lane_valid: assert property ( // [R3]
    dac_valid_r |-> dac_lane_r[0] && $past(analog))
    else $error("playback without sample lane");

  cov_edge_burst: cover property (
    state_r == TPWG_RUN && mode == TPWG_EDGE ##1 state_r == TPWG_IDLE);
  cov_analog_play: cover property (dac_valid_r ##1 !dac_valid_r);
  cov_level_run: cover property (running && mode == TPWG_LEVEL && pulse_r);
  cov_auto_en: cover property (self_test_done_i && ctrl_r[CTRL_AUTO_BIT]);
endmodule : tpwg_top
`default_nettype wire

//--- tpwg_far_end.sv
// Far-side model: external trigger source and fast DAC sink
`default_nettype none
module tpwg_far_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic lvl_i,
  input wire logic dac_valid_i,
  output logic trig_o,
  output logic [15:0] beats_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Trigger launched just after the edge, beats counted in the sink
  always_ff @(posedge clk_i) begin
    trig_o <= lvl_i;
    if (rst_i) begin
      beats_o <= 16'h0;
    end else if (dac_valid_i) begin
      beats_o <= beats_o + 16'h1;
    end
  end
endmodule : tpwg_far_end
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the pulse and waveform generator
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpwg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic lvl = 1'b0;
  logic trig;
  logic st_done = 1'b0;
  logic [47:0] adc = 48'h0;
  logic [63:0] aux;
  logic pulse;
  logic [31:0] dac;
  logic [1:0] lane;
  logic dval;
  logic out_en;
  logic [15:0] beats;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rnd = 32'h5fda;
  logic [31:0] q;
  logic [15:0] s [4];
  int c1;
  int c2;
  int c3;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  tpwg_top i_tpwg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .trig_i(trig),
    .self_test_done_i(st_done), .adc_i(adc), .aux_dac_o(aux),
    .pulse_o(pulse), .dac_data_o(dac), .dac_lane_o(lane),
    .dac_valid_o(dval), .out_en_o(out_en));
  tpwg_far_end i_tpwg_far_end (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl),
    .dac_valid_i(dval), .trig_o(trig), .beats_o(beats));
  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Rising edges of the pulse output over n cycles
  task automatic cnt(input int n, output int c);
    logic p;
    c = 0;
    p = pulse;
    repeat (n) begin
      @(posedge clk_i);
      if (pulse === 1'b1 && p !== 1'b1) c++;
      p = pulse;
    end
  endtask : cnt
  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_WIDTH, 32'h0);
    chk("width", WIDTH_RST, q);
    wb(1'b0, REG_RATE, 32'h0);
    chk("rate", RATE_RST, q);
    wb(1'b0, 8'h2c, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      adc[i*12+:12] <= rnd[11:0];
      wb(1'b1, {AUX_BLOCK, i[1:0], 2'b00}, {16'h0, rnd[15:0]});
      wb(1'b0, {ADC_BLOCK, i[1:0], 2'b00}, 32'h0);
      chk("adc", {20'h0, rnd[11:0]}, q);
      wb(1'b0, {AUX_BLOCK, i[1:0], 2'b00}, 32'h0);
      chk("aux", {16'h0, rnd[15:0]}, q);
      chk("aux_pin", {16'h0, rnd[15:0]}, {16'h0, aux[i*16+:16]});
    end
    wb(1'b1, REG_RATE, 32'd10_000_000);
    repeat (40) @(posedge clk_i);
    wb(1'b0, REG_PERIOD, 32'h0);
    chk("period", 32'd20, q);
    wb(1'b1, REG_WIDTH, 32'd200);
    wb(1'b0, REG_WIDTH, 32'h0);
    chk("width_clamp", 32'd95, q);
    wb(1'b1, REG_WIDTH, 32'd20);
    wb(1'b1, REG_SHOTS, 32'd3);
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, REG_CTRL, 32'h0);
      lvl <= p[0];
      wb(1'b1, REG_CTRL, {28'h0, p[0], 3'b001});
      lvl <= ~p[0];
      cnt(10, c1);
      lvl <= p[0];
      cnt(15, c2);
      lvl <= ~p[0];
      cnt(100, c3);
      chk("burst", 32'd3, c1 + c2 + c3);
    end
    wb(1'b1, REG_CTRL, 32'h0);
    lvl <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h3);
    lvl <= 1'b1;
    cnt(100, c1);
    chk("level_on", 32'h1, c1 >= 4);
    lvl <= 1'b0;
    cnt(25, c1);
    cnt(60, c1);
    chk("level_off", 32'h0, c1);
    wb(1'b1, REG_CTRL, 32'h5);
    lvl <= rnd[3];
    cnt(200, c1);
    chk("internal", 32'h1, c1 >= 9);
    chk("no_dac", 32'h0, dval);
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    cnt(40, c1);
    chk("disabled", 32'h0, c1);
    s[0] = 16'h8000;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      if (k > 0) s[k] = rnd[15:0] & 16'h3fff;
      wb(1'b1, REG_SAMPLE, {8'h01, 1'b0, k[6:0], s[k]});
    end
    wb(1'b1, REG_SLOT_CFG, {13'h0, 3'd1, 1'b0, 7'd3, 3'b0, 5'd1});
    wb(1'b1, REG_FORM_SEL, 32'h1);
    wb(1'b1, REG_CTRL, 32'h7);
    c1 = 0;
    while (dval !== 1'b1 && c1 < 60) begin
      @(posedge clk_i);
      c1++;
    end
    chk("start_delay", 32'd3, c1);
    chk("pair0", {s[1], SAMPLE_MIN}, dac);
    chk("lane0", 32'h3, {30'h0, lane});
    @(posedge clk_i);
    chk("pair1", {s[3], s[2]}, dac);
    chk("square_off", 32'h0, pulse);
    chk("beats", 32'h1, beats != 16'h0);
    @(posedge clk_i);
    chk("play_end", 32'h0, dval);
    chk("beat_count", 32'd2, {16'h0, beats});
    wb(1'b1, REG_CTRL, 32'h80);
    chk("auto_wait", 32'h0, out_en);
    st_done <= 1'b1;
    @(posedge clk_i);
    st_done <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("auto_en", 32'h1, out_en);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
